// ### inc/soft_reset_pkg.sv
// constants, field layout and carrier types for the peripheral software reset registers
package soft_reset_pkg;

  localparam int unsigned WORD_W = 32;
  localparam int unsigned SEL_W  = 4;

  // system control region and register offsets
  localparam logic [31:0] SYSCTL_BASE = 32'h400FE000;
  localparam logic [31:0] OFF_CTRL_B  = 32'h00000044;
  localparam logic [31:0] OFF_CTRL_C  = 32'h00000048;

  // reset values
  localparam logic [31:0] CTRL_B_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_C_RESET = 32'h00000000;

  // implemented bits; all others are reserved, read-only zero
  localparam logic [31:0] CTRL_B_IMPL = 32'h000F0111;
  localparam logic [31:0] CTRL_C_IMPL = 32'h0000201F;

  // peripheral_reset_ctrl_b field positions
  localparam int unsigned GP_COUNTER_A_BIT = 16;
  localparam int unsigned GP_COUNTER_B_BIT = 17;
  localparam int unsigned GP_COUNTER_C_BIT = 18;
  localparam int unsigned GP_COUNTER_D_BIT = 19;
  localparam int unsigned QUAD_DEC_BIT     = 8;
  localparam int unsigned SYNC_SERIAL_BIT  = 4;
  localparam int unsigned ASYNC_SERIAL_BIT = 0;

  // peripheral_reset_ctrl_c field positions
  localparam int unsigned MICRO_DMA_BIT = 13;
  localparam int unsigned IO_PORT_A_BIT = 0;
  localparam int unsigned IO_PORT_B_BIT = 1;
  localparam int unsigned IO_PORT_C_BIT = 2;
  localparam int unsigned IO_PORT_D_BIT = 3;
  localparam int unsigned IO_PORT_E_BIT = 4;

  // one classic wishbone request as the master presents it
  typedef struct packed {
    logic [31:0] adr;
    logic [31:0] dat;
    logic [3:0]  sel;
    logic        we;
  } wb_req_t;

  // one reset line per peripheral, high holds the peripheral in reset
  typedef struct packed {
    logic gp_counter_a_reset;
    logic gp_counter_b_reset;
    logic gp_counter_c_reset;
    logic gp_counter_d_reset;
    logic quadrature_decoder_reset;
    logic sync_serial_reset;
    logic async_serial_reset;
    logic micro_dma_reset;
    logic io_port_a_reset;
    logic io_port_b_reset;
    logic io_port_c_reset;
    logic io_port_d_reset;
    logic io_port_e_reset;
  } periph_reset_t;

endpackage

// ### design/wb_classic_handshake.sv
// single-wait-state acknowledge generator for a classic wishbone slave
module wb_classic_handshake (
  input  wire logic clk_i,      // system clock
  input  wire logic rst_i,      // synchronous reset, active high
  input  wire logic cyc_i,      // bus cycle
  input  wire logic stb_i,      // strobe
  output logic      ack_o,      // acknowledge
  output logic      launch_o,   // first cycle of a request, read data is sampled here
  output logic      commit_o    // edge at which the master takes the ack
);

  logic ack_reg;
  logic ack_next;

  // ack falls the cycle after it was given, so back-to-back cycles are never merged
  always_comb begin
    ack_next = cyc_i & stb_i & ~ack_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
    end
  end

  assign ack_o    = ack_reg;
  assign launch_o = cyc_i & stb_i & ~ack_reg;
  assign commit_o = cyc_i & stb_i & ack_reg;

endmodule

// ### design/masked_ctrl_reg.sv
// one 32-bit reset-control word whose writes are gated by a capabilities word
module masked_ctrl_reg #(
  parameter logic [31:0] IMPL_MASK  = 32'h00000000,
  parameter logic [31:0] RESET_VAL  = 32'h00000000
) (
  input  wire logic        clk_i,    // system clock
  input  wire logic        rst_i,    // synchronous reset, active high
  input  wire logic        wr_en_i,  // commit a write this edge
  input  wire logic [31:0] wdata_i,  // write data
  input  wire logic [3:0]  sel_i,    // byte enables
  input  wire logic [31:0] cap_i,    // capabilities word, one marks an implemented unit
  output logic      [31:0] value_o   // current contents
);

  logic [31:0] value_reg;
  logic [31:0] value_next;
  logic [31:0] wmask;

  function automatic logic [31:0] byte_mask(input logic [3:0] sel);
    byte_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // only bits that exist and whose unit is present can change
  always_comb begin
    wmask      = byte_mask(sel_i) & cap_i & IMPL_MASK;
    value_next = value_reg;
    if (wr_en_i) begin
      value_next = (value_reg & ~wmask) | (wdata_i & wmask);
    end
  end

  // all reset bits start at zero, peripherals run after power-on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_o = value_reg & IMPL_MASK;

endmodule

// ### design/periph_soft_reset_regs.sv
// peripheral software reset registers on a classic wishbone slave
// How it works
// - writes to ctrl_b only change bits enabled in capabilities word two
// - writes to ctrl_c only change bits enabled in capabilities word four
// - ctrl_b bits 16 to 19 reset general-purpose counters a to d
// - ctrl_b bit 8 resets the quadrature decoder
// - ctrl_b bit 4 resets the synchronous serial unit
// - ctrl_b bit 0 resets the asynchronous serial unit
// - ctrl_c bit 13 resets the micro dma unit
// - ctrl_c bits 0 to 4 reset io ports a to e
// - unassigned bits read zero and ignore writes; software preserves them
// - registers sit at base plus 0x044 and 0x048
module periph_soft_reset_regs (
  input  wire logic                         clk_i,                    // system clock, 50 MHz
  input  wire logic                         rst_i,                    // sync reset, active high
  input  wire logic                         cyc_i,                    // wishbone cycle
  input  wire logic                         stb_i,                    // wishbone strobe
  input  wire logic                         we_i,                     // wishbone write enable
  input  wire logic [31:0]                  adr_i,                    // wishbone byte address
  input  wire logic [31:0]                  dat_i,                    // wishbone write data
  input  wire logic [3:0]                   sel_i,                    // wishbone byte enables
  output logic      [31:0]                  dat_o,                    // wishbone read data
  output logic                              ack_o,                    // wishbone acknowledge
  input  wire logic [31:0]                  capabilities_word_two_i,  // unit-present mask, ctrl_b
  input  wire logic [31:0]                  capabilities_word_four_i, // unit-present mask, ctrl_c
  output soft_reset_pkg::periph_reset_t     periph_resets_o           // per-peripheral resets
);

  soft_reset_pkg::wb_req_t       req;
  soft_reset_pkg::periph_reset_t resets_reg;
  soft_reset_pkg::periph_reset_t resets_next;

  logic        launch;
  logic        commit;
  logic        hit_b;
  logic        hit_c;
  logic [31:0] ctrl_b;
  logic [31:0] ctrl_c;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // full-address compare against one register of the system control region
  function automatic logic addr_hit(input logic [31:0] adr, input logic [31:0] off);
    addr_hit = (adr == (soft_reset_pkg::SYSCTL_BASE + off));
  endfunction

  assign req = '{adr: adr_i, dat: dat_i, sel: sel_i, we: we_i};

  wb_classic_handshake u_handshake (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .ack_o    (ack_o),
    .launch_o (launch),
    .commit_o (commit)
  );

  // unmapped addresses are still acknowledged: reads return zero, writes are dropped
  assign hit_b = addr_hit(req.adr, soft_reset_pkg::OFF_CTRL_B);
  assign hit_c = addr_hit(req.adr, soft_reset_pkg::OFF_CTRL_C);

  masked_ctrl_reg #(
    .IMPL_MASK (soft_reset_pkg::CTRL_B_IMPL),
    .RESET_VAL (soft_reset_pkg::CTRL_B_RESET)
  ) u_ctrl_b (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_en_i (commit & req.we & hit_b),
    .wdata_i (req.dat),
    .sel_i   (req.sel),
    .cap_i   (capabilities_word_two_i),
    .value_o (ctrl_b)
  );

  masked_ctrl_reg #(
    .IMPL_MASK (soft_reset_pkg::CTRL_C_IMPL),
    .RESET_VAL (soft_reset_pkg::CTRL_C_RESET)
  ) u_ctrl_c (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_en_i (commit & req.we & hit_c),
    .wdata_i (req.dat),
    .sel_i   (req.sel),
    .cap_i   (capabilities_word_four_i),
    .value_o (ctrl_c)
  );

  // read data is captured on the first request cycle and held while ack stands
  always_comb begin
    rdata_next = rdata_reg;
    if (launch) begin
      rdata_next = 32'h00000000;
      if (!req.we && hit_b) begin
        rdata_next = ctrl_b;           // reserved bits already zero
      end else if (!req.we && hit_c) begin
        rdata_next = ctrl_c;
      end
    end
  end

  // a set bit holds its peripheral in reset, a clear bit releases it
  always_comb begin
    resets_next.gp_counter_a_reset       = ctrl_b[soft_reset_pkg::GP_COUNTER_A_BIT];
    resets_next.gp_counter_b_reset       = ctrl_b[soft_reset_pkg::GP_COUNTER_B_BIT];
    resets_next.gp_counter_c_reset       = ctrl_b[soft_reset_pkg::GP_COUNTER_C_BIT];
    resets_next.gp_counter_d_reset       = ctrl_b[soft_reset_pkg::GP_COUNTER_D_BIT];
    resets_next.quadrature_decoder_reset = ctrl_b[soft_reset_pkg::QUAD_DEC_BIT];
    resets_next.sync_serial_reset        = ctrl_b[soft_reset_pkg::SYNC_SERIAL_BIT];
    resets_next.async_serial_reset       = ctrl_b[soft_reset_pkg::ASYNC_SERIAL_BIT];
    resets_next.micro_dma_reset          = ctrl_c[soft_reset_pkg::MICRO_DMA_BIT];
    resets_next.io_port_a_reset          = ctrl_c[soft_reset_pkg::IO_PORT_A_BIT];
    resets_next.io_port_b_reset          = ctrl_c[soft_reset_pkg::IO_PORT_B_BIT];
    resets_next.io_port_c_reset          = ctrl_c[soft_reset_pkg::IO_PORT_C_BIT];
    resets_next.io_port_d_reset          = ctrl_c[soft_reset_pkg::IO_PORT_D_BIT];
    resets_next.io_port_e_reset          = ctrl_c[soft_reset_pkg::IO_PORT_E_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs come from flops so peripheral reset nets see no decode glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      resets_reg <= '0;
    end else begin
      resets_reg <= resets_next;
    end
  end

  assign dat_o           = rdata_reg;
  assign periph_resets_o = resets_reg;

endmodule

// ### tb/periph_soft_reset_regs_asserts.sv
// port-level checker for the peripheral software reset registers
module periph_soft_reset_regs_asserts (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic                          cyc_i,
  input wire logic                          stb_i,
  input wire logic                          we_i,
  input wire logic [31:0]                   adr_i,
  input wire logic [31:0]                   dat_i,
  input wire logic [3:0]                    sel_i,
  input wire logic [31:0]                   dat_o,
  input wire logic                          ack_o,
  input wire logic [31:0]                   capabilities_word_two_i,
  input wire logic [31:0]                   capabilities_word_four_i,
  input wire soft_reset_pkg::periph_reset_t periph_resets_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AB = soft_reset_pkg::SYSCTL_BASE + soft_reset_pkg::OFF_CTRL_B;
  localparam logic [31:0] AC = soft_reset_pkg::SYSCTL_BASE + soft_reset_pkg::OFF_CTRL_C;
  soft_reset_pkg::periph_reset_t p;
  logic [31:0] vb, vc, sm, mb, mc;
  logic        wr_ack;
  // reset lines folded back into register layout, so reads and writes compare directly
  assign p = periph_resets_o;
  assign vb = {12'h000, p.gp_counter_d_reset, p.gp_counter_c_reset, p.gp_counter_b_reset,
    p.gp_counter_a_reset, 7'h00, p.quadrature_decoder_reset, 3'h0, p.sync_serial_reset,
    3'h0, p.async_serial_reset};
  assign vc = {18'h00000, p.micro_dma_reset, 8'h00, p.io_port_e_reset, p.io_port_d_reset,
    p.io_port_c_reset, p.io_port_b_reset, p.io_port_a_reset};
  assign sm = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  assign mb = sm & capabilities_word_two_i & soft_reset_pkg::CTRL_B_IMPL;
  assign mc = sm & capabilities_word_four_i & soft_reset_pkg::CTRL_C_IMPL;
  assign wr_ack = ack_o && we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rd(a); ack_o && !we_i && adr_i == a; endsequence
  sequence s_wr(a); ack_o && we_i && adr_i == a; endsequence
  a_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_read_b_map: assert property (s_rd(AB) |-> dat_o == vb)
    else $error("ctrl_b read disagrees with reset lines");
  a_read_c_map: assert property (s_rd(AC) |-> dat_o == vc)
    else $error("ctrl_c read disagrees with reset lines");
  a_unmapped_zero: assert property (ack_o && !we_i && adr_i != AB && adr_i != AC |->
    dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_write_b_gated: assert property (s_wr(AB) |-> ##2
    vb == (($past(vb, 2) & ~$past(mb, 2)) | ($past(dat_i, 2) & $past(mb, 2))))
    else $error("ctrl_b write not gated");
  a_write_c_gated: assert property (s_wr(AC) |-> ##2
    vc == (($past(vc, 2) & ~$past(mc, 2)) | ($past(dat_i, 2) & $past(mc, 2))))
    else $error("ctrl_c write not gated");
  a_resets_hold: assert property (!$past(wr_ack) && !$past(wr_ack, 2) |->
    $stable(periph_resets_o))
    else $error("reset lines moved without a write");
endmodule

bind periph_soft_reset_regs periph_soft_reset_regs_asserts periph_soft_reset_regs_asserts_inst (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
  .capabilities_word_two_i(capabilities_word_two_i),
  .capabilities_word_four_i(capabilities_word_four_i), .periph_resets_o(periph_resets_o));

// ### tb/test_periph_soft_reset_regs.sv
// self-checking bench for the peripheral software reset registers
module test_periph_soft_reset_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] AB = soft_reset_pkg::SYSCTL_BASE + soft_reset_pkg::OFF_CTRL_B;
  localparam logic [31:0] AC = soft_reset_pkg::SYSCTL_BASE + soft_reset_pkg::OFF_CTRL_C;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, ack_o;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0, q, dat_o;
  logic [31:0] cap_b = 32'hFFFFFFFF, cap_c = 32'hFFFFFFFF;
  logic [3:0]  sel_i = 4'hF;
  soft_reset_pkg::periph_reset_t res;
  int n_fail = 0, num_checks = 0;
  always #10 clk_i = ~clk_i;
  periph_soft_reset_regs periph_soft_reset_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i),
    .dat_o(dat_o), .ack_o(ack_o), .capabilities_word_two_i(cap_b),
    .capabilities_word_four_i(cap_c), .periph_resets_o(res));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // request held until ack is sampled; the next call waits an edge, giving the idle cycle
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (n = 0; n < 20 && ack_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 20) n_fail++;
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(q, exp);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(AB, 32'h0);
    rd(AC, 32'h0);
    $display("test reset values done");
    xfer(1'b1, AB, 32'hFFFFFFFF, 4'hF);
    rd(AB, 32'h000F0111);
    chk({19'h0, res}, 32'h00001FC0);
    cap_b <= 32'h00010100;
    xfer(1'b1, AB, 32'h0, 4'hF);
    rd(AB, 32'h000E0011);
    cap_b <= 32'hFFFFFFFF;
    xfer(1'b1, AB, 32'h0, 4'h1);
    rd(AB, 32'h000E0000);
    $display("test ctrl_b gating done");
    cap_c <= 32'h00002005;
    xfer(1'b1, AC, 32'hFFFFFFFF, 4'hF);
    rd(AC, 32'h00002005);
    chk({19'h0, res}, 32'h00000E34);
    cap_c <= 32'hFFFFFFFF;
    xfer(1'b1, AC, 32'h0000201A, 4'hF);
    rd(AC, 32'h0000201A);
    chk({19'h0, res}, 32'h00000E2B);
    $display("test ctrl_c gating done");
    rd(32'h400FE040, 32'h0);
    xfer(1'b1, 32'h400FE04C, 32'hFFFFFFFF, 4'hF);
    rd(AB, 32'h000E0000);
    xfer(1'b1, AB, 32'h0, 4'hF);
    rd(AB, 32'h0);
    chk({19'h0, res}, 32'h0000002B);
    $display("test decode and release done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(AC, 32'h0);
    chk({19'h0, res}, 32'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule
